// ==== adcsc_pkg.sv ====
package adcsc_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NCH = 8;
    localparam int RES_W = 16;

    // ****************************************************************
    // Mode codes
    // ****************************************************************
    localparam logic [2:0] MODE_EXT = 3'h0;
    localparam logic [2:0] MODE_ACQ = 3'h1;
    localparam logic [2:0] MODE_INT = 3'h2;
    localparam logic [2:0] MODE_RSV_A = 3'h3;
    localparam logic [2:0] MODE_RST = 3'h4;
    localparam logic [2:0] MODE_RSV_B = 3'h5;
    localparam logic [2:0] MODE_PPD = 3'h6;
    localparam logic [2:0] MODE_FPD = 3'h7;

    // ****************************************************************
    // Range codes
    // ****************************************************************
    localparam logic [2:0] RNG_NONE = 3'h0;
    localparam logic [2:0] RNG_DEF = 3'h7;
    localparam logic [2:0] RNG_D3 = 3'h1;
    localparam logic [2:0] RNG_D6 = 3'h4;
    localparam logic [2:0] RNG_D12 = 3'h7;

    // ****************************************************************
    // Command byte fields
    // ****************************************************************
    localparam int BIT_CH_HI = 6;
    localparam int BIT_CH_LO = 4;
    localparam int BIT_DIFF = 3;
    localparam int BIT_RNG_HI = 2;
    localparam logic [3:0] LOW_NIB_CONV = 4'h0;
    localparam logic [3:0] LOW_NIB_MODE = 4'h8;
    localparam logic [3:0] RX_LAST = 4'h7;

    // ****************************************************************
    // Serial clock counts
    // ****************************************************************
    localparam logic [4:0] EXT_SAMPLE_FALL = 5'h0E;
    localparam logic [4:0] ACQ_SAMPLE_FALL = 5'h10;
    localparam logic [4:0] INT_START_FALL = 5'h08;
    localparam logic [7:0] INT_SAMPLE_TICK = 8'h0B;
    localparam logic [4:0] ADV_EXT = 5'h0D;
    localparam logic [4:0] ADV_ACQ = 5'h09;
    localparam logic [4:0] ADV_INT = 5'h0C;
    localparam logic [4:0] RES_BITS = 5'h10;

    // ****************************************************************
    // Internal clock timing
    // ****************************************************************
    localparam int REF_CLK_KHZ = 20000;
    localparam int INT_CLK_KHZ = 4500;
    localparam int INT_START_NS = 100;
    localparam logic [7:0] INT_TICK_CYC = 8'(REF_CLK_KHZ / INT_CLK_KHZ);
    localparam logic [7:0] INT_START_CYC = 8'((INT_START_NS * REF_CLK_KHZ + 999999) / 1000000);

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic diff;
        logic [2:0] rng;
    } adcsc_cfg_t;

    typedef struct packed {
        logic [2:0] chan;
        adcsc_cfg_t cfg;
    } adcsc_smp_t;

    typedef enum logic [2:0] {
        ADCSC_IDLE,
        ADCSC_RX,
        ADCSC_XWAIT,
        ADCSC_IWAIT,
        ADCSC_ICONV
    } adcsc_state_t;

    localparam adcsc_cfg_t CFG_DEFAULT = '{diff: 1'b0, rng: RNG_DEF};

endpackage : adcsc_pkg

// ==== adcsc_cfg_store.sv ====
`timescale 1ns/1ps
`default_nettype none

module adcsc_cfg_store #(
    parameter int NCH = adcsc_pkg::NCH
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_wr,
    input wire logic [2:0] i_wr_chan,
    input wire adcsc_pkg::adcsc_cfg_t i_wr_cfg,
    input wire logic i_set_def,
    input wire logic [2:0] i_rd_chan,
    output var adcsc_pkg::adcsc_cfg_t o_rd_cfg
);

    // ****************************************************************
    // Per-input configuration
    // ****************************************************************
    typedef struct packed {
        adcsc_pkg::adcsc_cfg_t [NCH-1:0] cfg;
    } adcsc_store_t;

    adcsc_store_t st_q;
    adcsc_store_t st_d;

    always_comb
    begin
        st_d = st_q;
        for (int i = 0; i < NCH; i++)
        begin
            if (i_set_def)
                st_d.cfg[i] = adcsc_pkg::CFG_DEFAULT;
            else if (i_wr && (i_wr_chan == 3'(i)))
                st_d.cfg[i] = i_wr_cfg;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            st_q <= {NCH{adcsc_pkg::CFG_DEFAULT}};
        else
            st_q <= st_d;
    end

    assign o_rd_cfg = st_q.cfg[i_rd_chan];

endmodule : adcsc_cfg_store

`default_nettype wire

// ==== adcsc_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

module adcsc_ctrl #(
    parameter int EXT_CONV_SCLKS = 2,
    parameter int INT_CONV_TICKS = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    input wire logic [15:0] i_result,
    output logic o_dout,
    output logic o_dout_oe,
    output logic o_done_strobe,
    output logic o_sample,
    output var adcsc_pkg::adcsc_smp_t o_smp,
    output logic [2:0] o_mode
);

    // ****************************************************************
    // Local constants and state
    // ****************************************************************
    localparam logic [4:0] EXT_DONE_FALL = adcsc_pkg::EXT_SAMPLE_FALL + 5'(EXT_CONV_SCLKS);
    localparam logic [7:0] INT_DONE_TICK = adcsc_pkg::INT_SAMPLE_TICK + 8'(INT_CONV_TICKS);

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic cs_s3;
        logic sclk_s1;
        logic sclk_s2;
        logic sclk_s3;
        logic din_s1;
        logic din_s2;
        adcsc_pkg::adcsc_state_t st;
        logic [7:0] sr;
        logic [3:0] rx_cnt;
        logic [4:0] fall_cnt;
        logic [7:0] cyc_cnt;
        logic [7:0] tick_cnt;
        logic [2:0] conv_mode;
        logic [2:0] mode;
        adcsc_pkg::adcsc_smp_t smp;
        logic sample;
        logic [15:0] rd_sr;
        logic [4:0] rd_left;
        logic dout;
        logic dout_oe;
        logic done;
        logic cfg_wr;
        logic [2:0] cfg_wr_chan;
        adcsc_pkg::adcsc_cfg_t cfg_wr_cfg;
        logic cfg_def;
    } adcsc_ctrl_t;

    adcsc_ctrl_t q;
    adcsc_ctrl_t d;

    logic rise;
    logic fall;
    logic start_ok;
    logic [4:0] shifted;
    logic [4:0] adv;
    logic [7:0] rx_byte;
    logic [2:0] rx_chan;
    logic [2:0] rx_rng;
    logic [4:0] nf;
    logic [7:0] nt;
    logic pwr_down;
    adcsc_pkg::adcsc_cfg_t rd_cfg;

    // ****************************************************************
    // Edge detect and start qualification
    // ****************************************************************
    // edges under select
    assign rise = !q.cs_s2 && q.sclk_s2 && !q.sclk_s3;
    // Select taken one stage older so a fall on the select rise still counts
    assign fall = !q.cs_s3 && !q.sclk_s2 && q.sclk_s3;
    assign shifted = adcsc_pkg::RES_BITS - q.rd_left;
    assign adv = (q.mode == adcsc_pkg::MODE_EXT) ? adcsc_pkg::ADV_EXT :
                 (q.mode == adcsc_pkg::MODE_ACQ) ? adcsc_pkg::ADV_ACQ :
                 (q.mode == adcsc_pkg::MODE_INT) ? adcsc_pkg::ADV_INT : adcsc_pkg::RES_BITS;
    assign start_ok = (q.st == adcsc_pkg::ADCSC_IDLE) && ((q.rd_left == 5'h00) || (shifted >= adv));
    assign rx_byte = {q.sr[6:0], q.din_s2};
    assign rx_chan = rx_byte[adcsc_pkg::BIT_CH_HI:adcsc_pkg::BIT_CH_LO];
    assign rx_rng = rx_byte[adcsc_pkg::BIT_RNG_HI:0];
    assign nf = q.fall_cnt + 5'h01;
    assign nt = q.tick_cnt + 8'h01;
    assign pwr_down = (q.mode == adcsc_pkg::MODE_PPD) || (q.mode == adcsc_pkg::MODE_FPD);

    adcsc_cfg_store #(
        .NCH(adcsc_pkg::NCH)
    ) u_cfg (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_wr(q.cfg_wr),
        .i_wr_chan(q.cfg_wr_chan),
        .i_wr_cfg(q.cfg_wr_cfg),
        .i_set_def(q.cfg_def),
        .i_rd_chan(rx_chan),
        .o_rd_cfg(rd_cfg)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        d = q;
        d.cs_s1 = i_cs_n;
        d.cs_s2 = q.cs_s1;
        d.cs_s3 = q.cs_s2;
        d.sclk_s1 = i_sclk;
        d.sclk_s2 = q.sclk_s1;
        d.sclk_s3 = q.sclk_s2;
        d.din_s1 = i_din;
        d.din_s2 = q.din_s1;
        d.sample = 1'b0;
        d.cfg_wr = 1'b0;
        d.cfg_def = 1'b0;
        d.dout_oe = !q.cs_s2;
        if (fall && (q.rd_left != 5'h00))
        begin
            d.dout = q.rd_sr[15];
            d.rd_sr = {q.rd_sr[14:0], 1'b0};
            d.rd_left = q.rd_left - 5'h01;
        end
        case (q.st)
            adcsc_pkg::ADCSC_IDLE:
            begin
                if (rise && q.din_s2 && start_ok)
                begin
                    d.st = adcsc_pkg::ADCSC_RX;
                    d.sr = 8'h01;
                    d.rx_cnt = 4'h1;
                    d.fall_cnt = 5'h00;
                    d.rd_left = 5'h00;
                    d.done = 1'b0;
                end
            end
            adcsc_pkg::ADCSC_RX:
            begin
                if (q.cs_s2)
                    d.st = adcsc_pkg::ADCSC_IDLE;
                else
                begin
                    if (fall)
                        d.fall_cnt = nf;
                    if (rise)
                    begin
                        d.sr = rx_byte;
                        d.rx_cnt = q.rx_cnt + 4'h1;
                    end
                    if (rise && (q.rx_cnt == adcsc_pkg::RX_LAST))
                    begin
                        d.st = adcsc_pkg::ADCSC_IDLE;
                        if (rx_byte[3:0] == adcsc_pkg::LOW_NIB_CONV)
                        begin
                            if (!pwr_down && !(rd_cfg.diff && rx_chan[0]))
                            begin
                                d.st = adcsc_pkg::ADCSC_XWAIT;
                                d.conv_mode = q.mode;
                                d.smp = '{chan: rx_chan, cfg: rd_cfg};
                            end
                        end
                        else if (rx_byte[3:0] == adcsc_pkg::LOW_NIB_MODE)
                        begin
                            if (rx_chan == adcsc_pkg::MODE_RST)
                            begin
                                d.mode = adcsc_pkg::MODE_EXT;
                                d.cfg_def = 1'b1;
                                d.done = 1'b0;
                            end
                            else if ((rx_chan != adcsc_pkg::MODE_RSV_A) && (rx_chan != adcsc_pkg::MODE_RSV_B))
                            begin
                                d.mode = rx_chan;
                                d.done = 1'b0;
                            end
                        end
                        else if (!rx_byte[adcsc_pkg::BIT_DIFF] || (!rx_chan[0] &&
                                 ((rx_rng == adcsc_pkg::RNG_D3) || (rx_rng == adcsc_pkg::RNG_D6) ||
                                  (rx_rng == adcsc_pkg::RNG_D12))))
                        begin
                            d.cfg_wr = 1'b1;
                            d.cfg_wr_chan = rx_chan;
                            d.cfg_wr_cfg = '{diff: rx_byte[adcsc_pkg::BIT_DIFF], rng: rx_rng};
                        end
                    end
                end
            end
            adcsc_pkg::ADCSC_XWAIT:
            begin
                // select may rise on the sampling fall
                if (q.cs_s2 && !fall)
                    d.st = adcsc_pkg::ADCSC_IDLE;
                else if (fall)
                begin
                    d.fall_cnt = nf;
                    if (q.conv_mode == adcsc_pkg::MODE_EXT)
                    begin
                        if (nf == adcsc_pkg::EXT_SAMPLE_FALL)
                            d.sample = 1'b1;
                        if (nf == EXT_DONE_FALL)
                        begin
                            d.st = adcsc_pkg::ADCSC_IDLE;
                            d.dout = i_result[15];
                            d.rd_sr = {i_result[14:0], 1'b0};
                            d.rd_left = adcsc_pkg::RES_BITS - 5'h01;
                        end
                    end
                    else if (q.conv_mode == adcsc_pkg::MODE_ACQ)
                    begin
                        if (nf == adcsc_pkg::ACQ_SAMPLE_FALL)
                        begin
                            d.sample = 1'b1;
                            d.st = adcsc_pkg::ADCSC_ICONV;
                            d.cyc_cnt = 8'h00;
                            d.tick_cnt = adcsc_pkg::INT_SAMPLE_TICK;
                        end
                    end
                    else if (nf == adcsc_pkg::INT_START_FALL)
                    begin
                        d.st = adcsc_pkg::ADCSC_IWAIT;
                        d.cyc_cnt = 8'h00;
                    end
                end
            end
            adcsc_pkg::ADCSC_IWAIT:
            begin
                d.cyc_cnt = q.cyc_cnt + 8'h01;
                if (q.cyc_cnt == adcsc_pkg::INT_START_CYC - 8'h01)
                begin
                    d.st = adcsc_pkg::ADCSC_ICONV;
                    d.cyc_cnt = 8'h00;
                    d.tick_cnt = 8'h00;
                end
            end
            adcsc_pkg::ADCSC_ICONV:
            begin
                d.cyc_cnt = q.cyc_cnt + 8'h01;
                if (q.cyc_cnt == adcsc_pkg::INT_TICK_CYC - 8'h01)
                begin
                    d.cyc_cnt = 8'h00;
                    d.tick_cnt = nt;
                    if (nt == adcsc_pkg::INT_SAMPLE_TICK)
                        d.sample = 1'b1;
                    if (nt == INT_DONE_TICK)
                    begin
                        d.st = adcsc_pkg::ADCSC_IDLE;
                        // First bit waits on the line so two bytes read all
                        d.dout = i_result[15];
                        d.rd_sr = {i_result[14:0], 1'b0};
                        d.rd_left = adcsc_pkg::RES_BITS - 5'h01;
                        d.done = (q.mode != adcsc_pkg::MODE_EXT);
                    end
                end
            end
            default:
                d.st = adcsc_pkg::ADCSC_IDLE;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            q <= '0;
            q.cs_s1 <= 1'b1;
            q.cs_s2 <= 1'b1;
            q.cs_s3 <= 1'b1;
            q.st <= adcsc_pkg::ADCSC_IDLE;
            q.mode <= adcsc_pkg::MODE_EXT;
            q.smp <= '{chan: 3'h0, cfg: adcsc_pkg::CFG_DEFAULT};
            q.cfg_wr_cfg <= adcsc_pkg::CFG_DEFAULT;
        end
        else
            q <= d;
    end

    assign o_dout = q.dout;
    assign o_dout_oe = q.dout_oe;
    assign o_done_strobe = q.done;
    assign o_sample = q.sample;
    assign o_smp = q.smp;
    assign o_mode = q.mode;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    property p_oe_off;
        q.cs_s2 |=> !o_dout_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("serial output driven while deselected");

    property p_dout_on_fall;
        $changed(o_dout) |-> $past(fall) || $past(q.st == adcsc_pkg::ADCSC_ICONV);
    endproperty
    a_dout_on_fall: assert property (p_dout_on_fall) else $error("serial output changed off a fall");

    property p_shift;
        (fall && (q.rd_left != 5'h00)) |=> (o_dout == $past(q.rd_sr[15])) && (q.rd_left == $past(q.rd_left) - 5'h01);
    endproperty
    a_shift: assert property (p_shift) else $error("result bit not shifted MSB first");

    property p_ext_low;
        (q.mode == adcsc_pkg::MODE_EXT) |-> !o_done_strobe;
    endproperty
    a_ext_low: assert property (p_ext_low) else $error("strobe high in external clock mode");

    property p_strobe_clr;
        (rise && q.din_s2 && start_ok) |=> !o_done_strobe && (q.st == adcsc_pkg::ADCSC_RX);
    endproperty
    a_strobe_clr: assert property (p_strobe_clr) else $error("strobe not cleared by start bit");

    property p_done_set;
        (q.st == adcsc_pkg::ADCSC_ICONV) ##1 (q.st == adcsc_pkg::ADCSC_IDLE) |->
            (o_done_strobe || (q.mode == adcsc_pkg::MODE_EXT)) && (q.rd_left == adcsc_pkg::RES_BITS - 5'h01);
    endproperty
    a_done_set: assert property (p_done_set) else $error("finished conversion did not raise strobe");

    property p_ext_sample;
        (o_sample && (q.conv_mode == adcsc_pkg::MODE_EXT)) |-> (q.fall_cnt == adcsc_pkg::EXT_SAMPLE_FALL);
    endproperty
    a_ext_sample: assert property (p_ext_sample) else $error("external sample not on fall 14");

    property p_acq_sample;
        (o_sample && (q.conv_mode == adcsc_pkg::MODE_ACQ)) |-> (q.fall_cnt == adcsc_pkg::ACQ_SAMPLE_FALL);
    endproperty
    a_acq_sample: assert property (p_acq_sample) else $error("acquisition sample not on fall 16");

    property p_int_sample;
        (o_sample && (q.conv_mode == adcsc_pkg::MODE_INT)) |-> (q.tick_cnt == adcsc_pkg::INT_SAMPLE_TICK);
    endproperty
    a_int_sample: assert property (p_int_sample) else $error("internal sample not on tick 11");

    property p_int_start;
        (q.st == adcsc_pkg::ADCSC_IWAIT) && $changed(q.st) |-> ##2 (q.st == adcsc_pkg::ADCSC_ICONV);
    endproperty
    a_int_start: assert property (p_int_start) else $error("internal clock start delay wrong");

    property p_reset_mode;
        q.cfg_def |-> (q.mode == adcsc_pkg::MODE_EXT) && !o_done_strobe;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("reset code did not restore mode");

    c_ext_sample: cover property (o_sample && (q.conv_mode == adcsc_pkg::MODE_EXT));
    c_acq_done: cover property (o_done_strobe && (q.conv_mode == adcsc_pkg::MODE_ACQ));
    c_int_done: cover property (o_done_strobe && (q.conv_mode == adcsc_pkg::MODE_INT));
    c_cfg_write: cover property (q.cfg_wr && q.cfg_wr_cfg.diff);

endmodule : adcsc_ctrl

`default_nettype wire

// ==== adcsc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module adcsc_host_model (
    input wire logic i_ref_clk,
    input wire logic i_dout,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din
);
    // ****
    // Serial master
    // ****
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end

    // steady 400 ns clock, idle low
    task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx, input logic sel);
        rx = 32'h0;
        o_cs_n = ~sel;
        for (int i = 0; i < n; i++)
        begin
            o_din = tx[31-i];
            repeat (4) @(negedge i_ref_clk);
            o_sclk = 1'b1;
            repeat (4) @(negedge i_ref_clk);
            rx = {rx[30:0], i_dout};
            o_sclk = 1'b0;
        end
    endtask : shift

    // Released data line keeps changing
    task automatic release_bus();
        o_cs_n = 1'b1;
        o_din = ~o_din;
        repeat (6) @(negedge i_ref_clk);
    endtask : release_bus
endmodule : adcsc_host_model

`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ****
    // Bench
    // ****
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [15:0] i_result = 16'h0000;
    wire logic cs_n;
    wire logic sclk;
    wire logic din;
    logic dout, dout_oe, done_strobe, sample;
    adcsc_pkg::adcsc_smp_t smp;
    logic [2:0] mode;
    logic [31:0] rx;
    logic [31:0] seed = 32'h00008E85;
    logic [6:0] exp_q[$];
    logic [7:0] mb[7] = '{8'h98, 8'hA8, 8'hB8, 8'hE8, 8'hD8, 8'hF8, 8'hC8};
    logic [2:0] me[7] = '{3'h1, 3'h2, 3'h2, 3'h6, 3'h6, 3'h7, 3'h0};
    int fail_count = 0;
    int cmp_count = 0;

    always #25 i_ref_clk = ~i_ref_clk;

    // Released line reads as the inverse of the last driven bit
    adcsc_host_model host_u (.i_ref_clk(i_ref_clk), .i_dout(dout_oe ? dout : ~dout), .o_cs_n(cs_n), .o_sclk(sclk),
        .o_din(din));
    adcsc_ctrl dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din),
        .i_result(i_result), .o_dout(dout), .o_dout_oe(dout_oe), .o_done_strobe(done_strobe),
        .o_sample(sample), .o_smp(smp), .o_mode(mode));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish

    task automatic wr(input logic [7:0] b);
        host_u.shift({b, 24'h0}, 8, rx, 1'b1);
        host_u.release_bus();
        cmp(16'(done_strobe), 16'h0000);
        cmp(16'(dout_oe), 16'h0000);
    endtask : wr

    task automatic conv(input logic [2:0] ch, input logic [6:0] e, input int n);
        logic [15:0] res;
        int k;
        seed = lfsr(seed);
        res = seed[15:0];
        i_result = res;
        exp_q.push_back(e);
        host_u.shift({1'b1, ch, 28'h0}, n, rx, 1'b1);
        if (n < 32)
        begin
            host_u.release_bus();
            k = 0;
            while (done_strobe !== 1'b1 && k < 400)
            begin
                @(negedge i_ref_clk);
                k++;
            end
            cmp(16'(done_strobe), 16'h0001);
            host_u.shift(32'h0, 16, rx, 1'b1);
        end
        else
            cmp(16'(done_strobe), 16'h0000);
        host_u.release_bus();
        cmp(rx[15:0], res);
    endtask : conv

    // Sampling pulses checked against queued channel and setup
    always @(negedge i_ref_clk)
        if (sample === 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp(16'(smp), 16'hFFFF);
            else
                cmp(16'(smp), 16'(exp_q.pop_front()));
        end

    initial
    begin
        repeat (40000) @(negedge i_ref_clk);
        fail_count++;
        tally_and_finish();
    end

    initial
    begin
        repeat (2) @(negedge i_ref_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_ref_clk);
        cmp(16'({dout_oe, done_strobe, mode, smp}), 16'h0007);
        $display("Reset test done");
        conv(3'h5, 7'h57, 32);
        wr(8'hAC);
        conv(3'h2, 7'h2C, 32);
        wr(8'hBC);
        conv(3'h3, 7'h37, 32);
        wr(8'hCA);
        conv(3'h4, 7'h47, 32);
        wr(8'h96);
        conv(3'h1, 7'h16, 32);
        $display("Config test done");
        for (int i = 0; i < 7; i++)
        begin
            wr(mb[i]);
            cmp(16'(mode), 16'(me[i]));
            if (me[i] == 3'h1 || me[i] == 3'h2)
                conv(3'h2, 7'h2C, (me[i] == 3'h1) ? 16 : 8);
            else if (me[i] != 3'h0)
                wr(8'hA0);
        end
        conv(3'h2, 7'h27, 32);
        $display("Mode test done");
        host_u.shift({8'h98, 24'h0}, 8, rx, 1'b0);
        host_u.release_bus();
        cmp(16'({dout_oe, mode}), 16'h0000);
        $display("Deselect test done");
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
